// [dv/phy_link_startup_control_bench.sv]
module phy_link_startup_control_bench import plsc_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int MAXW = 200;               // shortened long wait
   localparam int MINW = 20;                // shortened short wait
   logic core_clk = 1'h0, srst = 1'h1;
   plsc_bus_t bus = '0;
   logic loc_rcvr_ok = 1'h0, pcs_status_ok = 1'h0, permit = 1'h0;
   logic lock = 1'h0;
   logic [7:0] snr_metric = 8'h00;
   logic [1:0] tx_symb_in = SYM_POS, rx_symb, tx_symb_q;
   logic [31:0] rdata_q;
   plsc_txmode_t tx_mode_q;
   plsc_info_t info_q, rx_info;
   logic config_q, link_status_q, local_margin_ok, loc_data_ready_q;
   logic rem_rcvr_q, rem_drdy_q, wd_ok_q, rx_lock, rx_info_valid;
   logic pfc_reached, partner_pam3;
   int errors = 0, comparisons = 0, n, m;
   typedef struct packed {
      logic rcv, pcs; logic [7:0] snr; logic drdy, mrg;
   } plsc_row_t;
   // plain cases: readiness and margin against the reset threshold
   plsc_row_t rows [4] = '{'{1'h0, 1'h0, 8'h7F, 1'h0, 1'h0},
      '{1'h1, 1'h0, 8'h80, 1'h0, 1'h1}, '{1'h0, 1'h1, 8'hFF, 1'h0, 1'h1},
      '{1'h1, 1'h1, 8'h00, 1'h1, 1'h0}};
   always #10 core_clk = ~core_clk;
   plsc_ctrl #(.MAXWAIT_CYCLES(MAXW), .MINWAIT_CYCLES(MINW)) dut (
      .core_clk, .srst, .bus, .rdata_q, .loc_rcvr_ok, .pcs_status_ok,
      .snr_metric, .rx_symb, .rx_lock, .rx_info_valid, .rx_info,
      .pfc_reached, .partner_pam3, .tx_symb_in, .tx_symb_q, .tx_mode_q,
      .info_q, .config_q, .link_status_q, .local_margin_ok,
      .loc_data_ready_q, .rem_rcvr_q, .rem_drdy_q, .wd_ok_q);
   plsc_partner partner (.core_clk, .srst, .info_q, .tx_mode_q, .permit,
      .lock, .rx_symb, .rx_lock, .rx_info_valid, .rx_info, .pfc_reached,
      .partner_pam3);
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge core_clk);
      bus <= '{1'h1, 1'h0, a, d};
      @(posedge core_clk);
      bus.wr <= 1'h0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a, logic [31:0] exp, string what);
      @(posedge core_clk);
      bus <= '{1'h0, 1'h1, a, 8'h00};
      @(posedge core_clk);
      bus.rd <= 1'h0;
      #1 chk(what, rdata_q, exp);
   endtask
   // a used-up bound is a mismatch and ends the run
   task automatic limit(int k, int lim);
      if (k >= lim) begin
         errors++;
         close_out();
      end
   endtask
   task automatic wait_mode(plsc_txmode_t md, logic eq, int lim,
                            output int k);
      for (k = 0; ((tx_mode_q === md) !== eq) && k < lim; k++)
         @(posedge core_clk) #1;
      limit(k, lim);
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      int k;
      for (k = 0; s !== 1'h1 && k < lim; k++) @(posedge core_clk) #1;
      limit(k, lim);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'h0;
      rd(REG_CTRL, 32'h0, "ctrl_rst");
      rd(REG_MARGIN, {24'h0, MARGIN_RST}, "margin_rst");
      rd(REG_WDMIN, {24'h0, WDMIN_RST}, "wdmin_rst");
      wr(REG_STATUS, 8'hFF);
      rd(REG_STATUS, 32'h30, "status_rst");
      rd(4'h2, 32'h0, "unmapped");
      wr(REG_MARGIN, 8'h40);
      rd(REG_MARGIN, 32'h40, "margin_wr");
      wr(REG_MARGIN, MARGIN_RST);
      foreach (rows[i]) begin
         @(posedge core_clk);
         loc_rcvr_ok <= rows[i].rcv;
         pcs_status_ok <= rows[i].pcs;
         snr_metric <= rows[i].snr;
         repeat (3) @(posedge core_clk);
         #1 chk("loc_ready", 32'(loc_data_ready_q), 32'(rows[i].drdy));
         chk("margin", 32'(local_margin_ok), 32'(rows[i].mrg));
      end
      wait_hi(wd_ok_q, 2200);
      // master startup through to data
      {loc_rcvr_ok, pcs_status_ok, lock, snr_metric} <= {3'h7, 8'hFF};
      tx_symb_in <= 2'h2;
      // permission bit set too, so the outgoing field must carry it
      wr(REG_CTRL, 8'h07);
      repeat (3) @(posedge core_clk);
      #1 chk("silent_mode", 32'(tx_mode_q), 32'(TXM_Z));
      chk("silent_symb", 32'(tx_symb_q), 32'(SYM_ZERO));
      wait_mode(TXM_T, 1'h1, 100, n);
      chk("dwell", 32'(n >= MINW - 2 && n <= MINW + 3), 32'h1);
      chk("phase", 32'(info_q.phase), 32'(PHASE_TRAIN));
      chk("rcvr_bit", 32'(info_q.rcvr_ok), 32'h1);
      chk("role", 32'(config_q), 32'h1);
      chk("permit_bit", 32'(info_q.slave_tx_en), 32'h1);
      chk("ready_bit", 32'(info_q.data_ready), 32'h1);
      // idle is only reached once the partner saw the countdown phase
      wait_mode(TXM_I, 1'h1, 200, n);
      wait_mode(TXM_N, 1'h1, 200, n);
      chk("data_symb", 32'(tx_symb_q), 32'(SYM_ZERO));
      tx_symb_in <= SYM_NEG;
      wait_hi(link_status_q, 50);
      chk("pass_symb", 32'(tx_symb_q), 32'(SYM_NEG));
      repeat (250) @(posedge core_clk);
      rd(REG_STATUS, 32'h2FC7, "status_data");
      lock <= 1'h0;
      repeat (3) @(posedge core_clk);
      #1 chk("rem_lost", 32'({rem_rcvr_q, rem_drdy_q}), 32'h0);
      // reset control holds every flag low, registers survive
      wr(REG_CTRL, 8'h0B);
      repeat (2) @(posedge core_clk);
      #1 chk("ctl_reset", 32'({link_status_q, loc_data_ready_q, wd_ok_q,
         local_margin_ok, info_q, tx_mode_q}), 32'(TXM_Z));
      rd(REG_CTRL, 32'h0B, "ctrl_kept");
      // receiver never reliable: long wait runs out in training
      loc_rcvr_ok <= 1'h0;
      wr(REG_CTRL, 8'h03);
      wait_mode(TXM_T, 1'h1, 100, n);
      wait_mode(TXM_T, 1'h0, 400, m);
      chk("long_wait", 32'(n + m >= MAXW - 1 && n + m <= MAXW + 4), 32'h1);
      chk("fail_link", 32'(link_status_q), 32'h0);
      // slave held silent until the master permits
      wr(REG_CTRL, 8'h00);
      lock <= 1'h1;
      wr(REG_CTRL, 8'h01);
      repeat (MINW + 20) @(posedge core_clk);
      #1 chk("slave_wait", 32'({config_q, tx_mode_q}), 32'(TXM_Z));
      permit <= 1'h1;
      wait_mode(TXM_T, 1'h1, 100, n);
      srst <= 1'h1;
      repeat (2) @(posedge core_clk);
      srst <= 1'h0;
      rd(REG_CTRL, 32'h0, "ctrl_srst");
      chk("mode_srst", 32'(tx_mode_q), 32'(TXM_Z));
      close_out();
   end
endmodule // phy_link_startup_control_bench

// [dv/plsc_partner.sv]
// ------------------------------------------------------------------
// remote link partner, as seen through the field decoder
// ------------------------------------------------------------------
module plsc_partner
   import plsc_pkg::*;
(
   input  logic                   core_clk,      // core clock
   input  logic                   srst,          // sync reset, high
   input  plsc_pkg::plsc_info_t   info_q,        // our outgoing field
   input  plsc_pkg::plsc_txmode_t tx_mode_q,     // our transmit mode
   input  logic                   permit,        // master lets slave talk
   input  logic                   lock,          // decoder locked, ready
   output logic [1:0]             rx_symb,       // received symbol
   output logic                   rx_lock,       // decoder locked
   output logic                   rx_info_valid, // field pulse
   output plsc_pkg::plsc_info_t   rx_info,       // decoded field
   output logic                   pfc_reached,   // switch point seen
   output logic                   partner_pam3   // partner is ternary
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0]           cnt_q;   // spacing of decoded fields
   logic [1:0]           sym_q;   // symbol pattern step
   plsc_pkg::plsc_info_t fld;     // field the partner sends
   // permission, receiver and ready bits of the partner
   assign fld = '{PHASE_TRAIN, lock, permit, lock, 3'h0};
   // outputs defined before the first edge
   initial begin
      {rx_symb, rx_lock, rx_info_valid, rx_info} = '0;
      {pfc_reached, partner_pam3, cnt_q, sym_q} = '0;
   end
   // field every eighth cycle; between pulses the bus is not held
   always @(posedge core_clk) begin
      cnt_q <= srst ? 3'h0 : cnt_q + 3'h1;
      sym_q <= srst ? 2'h0 : sym_q + 2'h1;
      rx_lock <= lock;
      rx_info_valid <= (cnt_q == 3'h7);
      rx_info <= (cnt_q == 3'h7) ? fld : ~fld;
      // only ternary levels, changing every symbol
      rx_symb <= sym_q[0] ? SYM_ZERO : (sym_q[1] ? SYM_NEG : SYM_POS);
      // follows our countdown and idle, as a real partner would
      pfc_reached <= (info_q.phase == PHASE_CDOWN);
      partner_pam3 <= (tx_mode_q == TXM_I);
   end
endmodule // plsc_partner

// [hdl/plsc_ctrl.sv]
module plsc_ctrl #(
   parameter int unsigned MAXWAIT_CYCLES = plsc_pkg::MAXWAIT_CYC, // long
   parameter int unsigned MINWAIT_CYCLES = plsc_pkg::MINWAIT_CYC  // short
) (
   input  logic                 core_clk,       // 50 MHz core clock
   input  logic                 srst,           // sync reset, high
   input  plsc_pkg::plsc_bus_t  bus,            // register port
   output logic [31:0]          rdata_q,        // read data, next cycle
   input  logic                 loc_rcvr_ok,    // receiver reliable
   input  logic                 pcs_status_ok,  // coding sublayer OK
   input  logic [7:0]           snr_metric,     // receiver margin
   input  logic [1:0]           rx_symb,        // received ternary
   input  logic                 rx_lock,        // field decoder locked
   input  logic                 rx_info_valid,  // field decoded, pulse
   input  plsc_pkg::plsc_info_t rx_info,        // received field
   input  logic                 pfc_reached,    // switch frame reached
   input  logic                 partner_pam3,   // partner now ternary
   input  logic [1:0]           tx_symb_in,     // coder symbol
   output logic [1:0]           tx_symb_q,      // line symbol
   output plsc_pkg::plsc_txmode_t tx_mode_q,    // transmit mode
   output plsc_pkg::plsc_info_t info_q,         // outgoing field
   output logic                 config_q,       // 1 master, 0 slave
   output logic                 link_status_q,  // 1 OK, 0 FAIL
   output logic                 local_margin_ok,// margin flag
   output logic                 loc_data_ready_q, // local ready
   output logic                 rem_rcvr_q,     // remote receiver
   output logic                 rem_drdy_q,     // remote ready
   output logic                 wd_ok_q         // activity watchdog
);
   import plsc_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic at_least(input logic [7:0] a,
                                     input logic [7:0] b);
      return a >= b;
   endfunction

   function automatic plsc_txmode_t mode_of(input plsc_state_t s);
      case (s)
         ST_SEND_DATA:          return TXM_N;
         ST_IDLE1, ST_IDLE2:    return TXM_I;
         ST_TRAINING,
         ST_COUNTDOWN:          return TXM_T;
         default:               return TXM_Z;
      endcase
   endfunction

   // only the three legal codes pass; the fourth becomes zero
   function automatic logic [1:0] ternary(input logic [1:0] s);
      return (s == SYM_POS || s == SYM_NEG) ? s : SYM_ZERO;
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   plsc_ctrl_t  ctrl_q;                         // control register
   logic [7:0]  margin_thr_q;                   // margin threshold
   logic [7:0]  wd_min_q;                       // transitions needed
   plsc_state_t state_q, state_d;               // control state
   logic        slave_en_rx_q;                  // partner permission
   logic        max_exp, min_exp;               // timer flags
   logic [1:0]  rx_prev_q;                      // last rx symbol
   logic [WD_W-1:0] wd_cnt_q;                   // window position
   logic [7:0]  tr_cnt_q;                       // transitions seen

   // reset control bit reaches everything but the register file,
   // otherwise software could never take it back off
   // sublayer-wide reset
   wire pma_rst = srst || ctrl_q.reset;

   // ----------------------------------------------------------------
   // register port decode
   // ----------------------------------------------------------------
   wire wr_ctrl   = bus.wr && bus.addr == REG_CTRL;
   wire wr_margin = bus.wr && bus.addr == REG_MARGIN;
   wire wr_wdmin  = bus.wr && bus.addr == REG_WDMIN;
   plsc_status_t status;
   assign status = '{min_exp: min_exp, max_exp: max_exp,
                     wd_ok: wd_ok_q, margin_ok: local_margin_ok,
                     rem_drdy: rem_drdy_q, rem_rcvr: rem_rcvr_q,
                     loc_drdy: loc_data_ready_q,
                     link_ok: link_status_q, tx_mode: tx_mode_q,
                     state: state_q};
   wire [31:0] rd_mux =
      (bus.addr == REG_CTRL)   ? {24'h000000, ctrl_q}       :
      (bus.addr == REG_MARGIN) ? {24'h000000, margin_thr_q} :
      (bus.addr == REG_WDMIN)  ? {24'h000000, wd_min_q}     :
      (bus.addr == REG_STATUS) ? {18'h00000, status}        :
                                 32'h00000000;

   // writes land at once; unmapped addresses read zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_q       <= '0;
         margin_thr_q <= MARGIN_RST;
         wd_min_q     <= WDMIN_RST;
         rdata_q      <= '0;
      end else begin
         if (wr_ctrl)   ctrl_q       <= bus.wdata;
         if (wr_margin) margin_thr_q <= bus.wdata;
         if (wr_wdmin)  wd_min_q     <= bus.wdata;
         // data stand for the one cycle after the strobe only
         rdata_q <= bus.rd ? rd_mux : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // receive side flags
   // ----------------------------------------------------------------
   wire healthy = loc_rcvr_ok && pcs_status_ok && wd_ok_q;

   // flags from the partner's field; lost lock drops them at once
   always_ff @(posedge core_clk) begin
      if (pma_rst || !rx_lock) begin
         rem_rcvr_q    <= 1'b0;
         rem_drdy_q    <= 1'b0;
         slave_en_rx_q <= 1'b0;
      end else if (rx_info_valid) begin
         rem_rcvr_q    <= rx_info.rcvr_ok;
         rem_drdy_q    <= rx_info.data_ready;
         slave_en_rx_q <= rx_info.slave_tx_en;
      end
   end

   // local flags, all cleared while in reset
   always_ff @(posedge core_clk) begin
      if (pma_rst) begin
         loc_data_ready_q <= 1'b0;
         local_margin_ok  <= 1'b0;
      end else begin
         loc_data_ready_q <= loc_rcvr_ok && pcs_status_ok;
         local_margin_ok  <= at_least(snr_metric, margin_thr_q);
      end
   end

   // ----------------------------------------------------------------
   // ternary activity watchdog
   // ----------------------------------------------------------------
   // verdict only at window end, so it lags activity by one window
   wire wd_end = wd_cnt_q == WD_WIN_LAST;
   wire moved  = rx_symb != rx_prev_q;
   always_ff @(posedge core_clk) begin
      if (pma_rst) begin
         rx_prev_q <= SYM_ZERO;
         wd_cnt_q  <= '0;
         tr_cnt_q  <= '0;
         wd_ok_q   <= 1'b0;
      end else begin
         rx_prev_q <= rx_symb;
         wd_cnt_q  <= wd_cnt_q + 1'b1;
         if (wd_end) begin
            wd_ok_q  <= at_least(tr_cnt_q, wd_min_q);
            tr_cnt_q <= '0;
         end else if (moved && tr_cnt_q != 8'hFF) begin
            tr_cnt_q <= tr_cnt_q + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   wire entering  = state_d != state_q;
   wire max_start = entering && state_d == ST_INIT_MAX;
   wire max_stop  = entering && (state_d == ST_SEND_DATA ||
                                 state_d == ST_DISABLE);
   wire min_start = entering && (state_d == ST_SILENT ||
                    state_d == ST_TRAINING || state_d == ST_IDLE2 ||
                    state_d == ST_SEND_DATA);

   plsc_timer #(.LIMIT(MAXWAIT_CYCLES)) u_maxwait (
      .core_clk  (core_clk),
      .srst      (pma_rst),
      .start     (max_start),
      .stop      (max_stop),
      .expired_q (max_exp)
   );

   plsc_timer #(.LIMIT(MINWAIT_CYCLES)) u_minwait (
      .core_clk  (core_clk),
      .srst      (pma_rst),
      .start     (min_start),
      .stop      (1'b0),
      .expired_q (min_exp)
   );

   // ----------------------------------------------------------------
   // control state machine
   // ----------------------------------------------------------------
   // expiry with a fault fails
   wire max_fail = max_exp && !healthy;
   wire drop     = !ctrl_q.link_en || max_fail ||
                   (state_q == ST_SEND_DATA && !healthy);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_DISABLE:
            if (ctrl_q.link_en) state_d = ST_INIT_MAX;
         ST_INIT_MAX:
            state_d = ST_SILENT;
         ST_SILENT:
            if (min_exp && (ctrl_q.master ||
                (slave_en_rx_q && local_margin_ok)))
               state_d = ST_TRAINING;
         ST_TRAINING:
            if (min_exp && loc_rcvr_ok && rem_rcvr_q)
               state_d = ST_COUNTDOWN;
         ST_COUNTDOWN:
            if (pfc_reached) state_d = ST_IDLE1;
         ST_IDLE1:
            if (partner_pam3) state_d = ST_IDLE2;
         ST_IDLE2:
            if (min_exp && loc_data_ready_q && rem_drdy_q)
               state_d = ST_SEND_DATA;
         ST_SEND_DATA:
            state_d = ST_SEND_DATA;
         default:
            state_d = ST_DISABLE;
      endcase
      if (drop) state_d = ST_DISABLE;
   end

   // state, selected mode and the outgoing field
   always_ff @(posedge core_clk) begin
      if (pma_rst) begin
         state_q   <= ST_DISABLE;
         tx_mode_q <= TXM_Z;
         info_q    <= '0;
      end else begin
         state_q   <= state_d;
         tx_mode_q <= mode_of(state_d);
         info_q.phase       <= (state_d == ST_COUNTDOWN) ? PHASE_CDOWN
                                                         : PHASE_TRAIN;
         info_q.rcvr_ok     <= loc_rcvr_ok;
         info_q.slave_tx_en <= ctrl_q.master && ctrl_q.slave_tx_en;
         info_q.data_ready  <= loc_data_ready_q;
         info_q.rsvd        <= '0;
      end
   end

   // ----------------------------------------------------------------
   // line symbols, role and link health
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (pma_rst) begin
         tx_symb_q     <= SYM_ZERO;
         config_q      <= 1'b0;
         link_status_q <= 1'b0;
      end else begin
         tx_symb_q     <= (tx_mode_q == TXM_Z) ? SYM_ZERO
                                               : ternary(tx_symb_in);
         config_q      <= ctrl_q.master;
         link_status_q <= healthy && ctrl_q.link_en &&
                          state_q == ST_SEND_DATA;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_symb_ternary: assert property (@(posedge core_clk)
      disable iff (srst) tx_symb_q != 2'h2)
      else $error("line symbol outside the ternary set");

   a_slave_waits: assert property (@(posedge core_clk)
      disable iff (pma_rst)
      state_q == ST_SILENT && !ctrl_q.master && !slave_en_rx_q
      |=> state_q != ST_TRAINING)
      else $error("slave trained without permission");

   a_ready_and: assert property (@(posedge core_clk)
      disable iff (pma_rst)
      ##1 loc_data_ready_q == $past(loc_rcvr_ok && pcs_status_ok))
      else $error("local ready not the and of both");

   a_phase_cdown: assert property (@(posedge core_clk)
      disable iff (pma_rst)
      state_q == ST_COUNTDOWN |-> info_q.phase == PHASE_CDOWN)
      else $error("countdown phase bits wrong");

   a_rem_lost: assert property (@(posedge core_clk)
      disable iff (srst) !rx_lock |=> !rem_rcvr_q && !rem_drdy_q)
      else $error("remote status kept without a field");

   a_max_fail: assert property (@(posedge core_clk)
      disable iff (pma_rst)
      max_exp && !healthy |=> state_q == ST_DISABLE ##1 !link_status_q)
      else $error("long wait fault did not fail the link");

   a_min_dwell: assert property (@(posedge core_clk)
      disable iff (pma_rst)
      state_q == ST_TRAINING && !min_exp
      |=> state_q == ST_TRAINING || state_q == ST_DISABLE)
      else $error("left training before short wait");

   a_silent_zero: assert property (@(posedge core_clk)
      disable iff (pma_rst)
      state_q == ST_SILENT |-> tx_mode_q == TXM_Z ##1 tx_symb_q == SYM_ZERO)
      else $error("silent state not sending zeros");

   a_data_mode: assert property (@(posedge core_clk)
      disable iff (pma_rst)
      $rose(state_q == ST_SEND_DATA) |-> tx_mode_q == TXM_N && !max_exp)
      else $error("data state entry mode or long wait wrong");

   a_reset_flags: assert property (@(posedge core_clk)
      disable iff (srst)
      ctrl_q.reset |=> !link_status_q && !loc_data_ready_q &&
                       !rem_rcvr_q && !wd_ok_q && !local_margin_ok)
      else $error("flag not cleared under reset control");
endmodule // plsc_ctrl

// [hdl/plsc_pkg.sv]
package plsc_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ       = 50000;         // core_clk rate
   localparam int MAXWAIT_US    = 97500;         // long wait, 97.5 ms
   localparam int MINWAIT_US    = 975;           // short wait, 975 us
   // nominal figure sits mid tolerance, so no rounding is needed
   localparam int MAXWAIT_CYC   = MAXWAIT_US * (CLK_KHZ / 1000);
   localparam int MINWAIT_CYC   = MINWAIT_US * (CLK_KHZ / 1000);
   localparam int TMR_W         = 23;            // fits 4,875,000
   localparam int WD_W          = 10;            // watchdog window width
   localparam logic [WD_W-1:0] WD_WIN_LAST = 10'h3FF; // 1024-cycle window

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;     // control bits
   localparam logic [3:0] REG_MARGIN = 4'h4;     // margin threshold
   localparam logic [3:0] REG_WDMIN  = 4'h8;     // min transitions
   localparam logic [3:0] REG_STATUS = 4'hC;     // read-only status
   localparam logic [7:0] MARGIN_RST = 8'h80;    // threshold at reset
   localparam logic [7:0] WDMIN_RST  = 8'h10;    // transitions at reset

   // ----------------------------------------------------------------
   // line symbols and training field phases
   // ----------------------------------------------------------------
   localparam logic [1:0] SYM_ZERO    = 2'h0;    // ternary 0
   localparam logic [1:0] SYM_POS     = 2'h1;    // ternary +1
   localparam logic [1:0] SYM_NEG     = 2'h3;    // ternary -1
   localparam logic [1:0] PHASE_TRAIN = 2'h0;    // training phase
   localparam logic [1:0] PHASE_CDOWN = 2'h1;    // countdown phase

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {TXM_N, TXM_I, TXM_T, TXM_Z} plsc_txmode_t;
   typedef enum logic [3:0] {
      ST_DISABLE, ST_INIT_MAX, ST_SILENT, ST_TRAINING,
      ST_COUNTDOWN, ST_IDLE1, ST_IDLE2, ST_SEND_DATA
   } plsc_state_t;
   typedef struct packed {
      logic [1:0] phase;        // top two bits of the field
      logic       rcvr_ok;      // receiver status bit
      logic       slave_tx_en;  // slave may transmit
      logic       data_ready;   // ready to receive data
      logic [2:0] rsvd;         // sent as zero
   } plsc_info_t;
   typedef struct packed {
      logic [3:0] rsvd;         // reserved
      logic       reset;        // attachment sublayer reset
      logic       slave_tx_en;  // master ready for slave
      logic       master;       // role: 1 master, 0 slave
      logic       link_en;      // link control enable
   } plsc_ctrl_t;
   typedef struct packed {
      logic       min_exp;      // short wait expired
      logic       max_exp;      // long wait expired
      logic       wd_ok;        // activity watchdog
      logic       margin_ok;    // local margin
      logic       rem_drdy;     // remote data ready
      logic       rem_rcvr;     // remote receiver status
      logic       loc_drdy;     // local data ready
      logic       link_ok;      // link health
      logic [1:0] tx_mode;      // transmit mode
      logic [3:0] state;        // control state
   } plsc_status_t;
   typedef struct packed {
      logic       wr;           // write strobe
      logic       rd;           // read strobe
      logic [3:0] addr;         // byte address
      logic [7:0] wdata;        // write data, low byte
   } plsc_bus_t;
endpackage : plsc_pkg

// [hdl/plsc_timer.sv]
module plsc_timer #(
   parameter int unsigned LIMIT = 16            // cycles to expiry
) (
   input  logic core_clk,                       // core clock
   input  logic srst,                           // sync reset, high
   input  logic start,                          // (re)start pulse
   input  logic stop,                           // stop pulse
   output logic expired_q                       // level, until restart or stop
);
   import plsc_pkg::*;

   // ----------------------------------------------------------------
   // down counter
   // ----------------------------------------------------------------
   logic [TMR_W-1:0] cnt_q;                     // cycles left
   logic             run_q;                     // timer running
   wire              hit = run_q && (cnt_q == '0);

   // start wins over stop, so a restart is never lost
   always_ff @(posedge core_clk) begin
      if (srst || stop && !start) begin
         cnt_q     <= '0;
         run_q     <= 1'b0;
         expired_q <= 1'b0;
      end else if (start) begin
         cnt_q     <= TMR_W'(LIMIT - 1);
         run_q     <= 1'b1;
         expired_q <= 1'b0;
      end else if (hit) begin
         run_q     <= 1'b0;
         expired_q <= 1'b1;
      end else if (run_q) begin
         cnt_q     <= cnt_q - 1'b1;
      end
   end
endmodule // plsc_timer
